// File: common/pmo_pkg.sv
// constants for the two-channel pwm module control and output stage
// assumes an apb slave at a fixed base, 32-bit data, word-aligned registers
package pmo_pkg;
	// address decode
	localparam logic [31:0] PMO_BASE_ADDR = 32'h4002_8000;
	localparam int          PMO_OFF_W     = 12;
	localparam logic [31:0] PMO_RST_VAL   = 32'h0000_0000;
	// register offsets
	localparam logic [11:0] PMO_OFF_MCTL  = 12'h000;
	localparam logic [11:0] PMO_OFF_SYNC  = 12'h004;
	localparam logic [11:0] PMO_OFF_PEN   = 12'h008;
	localparam logic [11:0] PMO_OFF_INV   = 12'h00c;
	localparam logic [11:0] PMO_OFF_FLT   = 12'h010;
	localparam logic [11:0] PMO_OFF_MIEN  = 12'h014;
	localparam logic [11:0] PMO_OFF_MRIS  = 12'h018;
	localparam logic [11:0] PMO_OFF_MISC  = 12'h01c;
	localparam logic [11:0] PMO_OFF_STAT  = 12'h020;
	localparam logic [11:0] PMO_OFF_GCTL  = 12'h040;
	localparam logic [11:0] PMO_OFF_GIEN  = 12'h044;
	localparam logic [11:0] PMO_OFF_GRIS  = 12'h048;
	localparam logic [11:0] PMO_OFF_GISC  = 12'h04c;
	localparam logic [11:0] PMO_OFF_LOAD  = 12'h050;
	localparam logic [11:0] PMO_OFF_COUNT = 12'h054;
	localparam logic [11:0] PMO_OFF_CMPA  = 12'h058;
	localparam logic [11:0] PMO_OFF_CMPB  = 12'h05c;
	localparam logic [11:0] PMO_OFF_ACTA  = 12'h060;
	localparam logic [11:0] PMO_OFF_ACTB  = 12'h064;
	localparam logic [11:0] PMO_OFF_DBCTL = 12'h068;
	localparam logic [11:0] PMO_OFF_DBRIS = 12'h06c;
	localparam logic [11:0] PMO_OFF_DBFAL = 12'h070;
	// field positions
	localparam int PMO_BIT_QUPD0  = 0;
	localparam int PMO_BIT_RST0   = 0;
	localparam int PMO_BIT_IFAULT = 16;
	localparam int PMO_BIT_IGEN0  = 0;
	localparam int PMO_BIT_EN     = 0;
	localparam int PMO_BIT_MODE   = 1;
	localparam int PMO_BIT_DBGRUN = 2;
	localparam int PMO_BIT_LDUPD  = 3;
	localparam int PMO_BIT_CAUPD  = 4;
	localparam int PMO_BIT_CBUPD  = 5;
	localparam int PMO_BIT_DBEN   = 0;
	localparam int PMO_GCTL_W     = 6;
	// counter events, also the order actions are applied in
	localparam int PMO_EV_ZERO = 0;
	localparam int PMO_EV_LOAD = 1;
	localparam int PMO_EV_AUP  = 2;
	localparam int PMO_EV_ADN  = 3;
	localparam int PMO_EV_BUP  = 4;
	localparam int PMO_EV_BDN  = 5;
	localparam int PMO_NUM_EV  = 6;
	localparam int PMO_ACT_W   = 2 * PMO_NUM_EV;
	// per-event actions
	localparam logic [1:0] PMO_ACT_NONE = 2'h0;
	localparam logic [1:0] PMO_ACT_TOG  = 2'h1;
	localparam logic [1:0] PMO_ACT_LOW  = 2'h2;
	localparam logic [1:0] PMO_ACT_HIGH = 2'h3;
	localparam int         PMO_NUM_CH   = 2;
endpackage

// File: core/pmo_ctrl.sv
// pwm module: apb registers, generator 0, dead band, output stages, irq
// assumes a single pclk domain; fault and debug stall pins are asynchronous
`timescale 1ns/100ps

module pmo_ctrl
	import pmo_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input  wire logic        pclk,             // bus clock, 125 mhz
	input  wire logic        presetn,          // async reset, low
	input  wire logic        psel,             // apb select
	input  wire logic        penable,          // apb access phase
	input  wire logic        pwrite,           // apb direction
	input  wire logic [31:0] paddr,            // apb byte address
	input  wire logic [31:0] pwdata,           // apb write data
	output logic      [31:0] prdata,           // apb read data
	output logic             pready,           // apb ready
	output logic             pslverr,          // apb error
	input  wire logic        fault_in,         // fault pin, high active
	input  wire logic        debug_stall,      // debugger halt
	output logic             output_channel_0, // pin 0
	output logic             output_channel_1, // pin 1
	output logic             irq               // level interrupt
);
	logic                  acc;
	logic                  hit;
	logic                  mapped;
	logic                  wr;
	logic [PMO_OFF_W-1:0]  off;
	logic [31:0]           rd_val;
	logic                  fault_s;
	logic                  dbg_s;
	logic                  fault_cond;
	logic                  queued;
	logic                  rst_pend;
	logic [1:0]            pin_en;
	logic [1:0]            inv;
	logic [1:0]            flt_force;
	logic                  mien_fault;
	logic                  mien_gen;
	logic                  fault_latch;
	logic [PMO_GCTL_W-1:0] gctl;
	logic [PMO_NUM_EV-1:0] gien;
	logic [PMO_NUM_EV-1:0] gris;
	logic                  gen_int;
	logic [CNT_W-1:0]      load_reg;
	logic [CNT_W-1:0]      cmpa_reg;
	logic [CNT_W-1:0]      cmpb_reg;
	logic [CNT_W-1:0]      load_act;
	logic [CNT_W-1:0]      cmpa_act;
	logic [CNT_W-1:0]      cmpb_act;
	logic [PMO_ACT_W-1:0]  act_a;
	logic [PMO_ACT_W-1:0]  act_b;
	logic                  db_en;
	logic [CNT_W-1:0]      db_rise;
	logic [CNT_W-1:0]      db_fall;
	logic [CNT_W-1:0]      cnt;
	logic                  dir_up;
	logic                  halt;
	logic                  tick;
	logic                  at_zero;
	logic [PMO_NUM_EV-1:0] ev;
	logic                  gen_a;
	logic                  gen_b;
	logic                  next_gen_a;
	logic                  next_gen_b;
	logic                  db0;
	logic                  db1;
	logic [CNT_W-1:0]      rise_cnt;
	logic [CNT_W-1:0]      fall_cnt;

	// bus decode against the unit base
	assign acc = psel & penable & pready;
	assign hit = (paddr[31:PMO_OFF_W] == PMO_BASE_ADDR[31:PMO_OFF_W]);
	assign off = paddr[PMO_OFF_W-1:0];
	assign wr  = acc & pwrite & hit & mapped;

	// read mux; unused bits read zero, writes to them ignored
	always_comb begin
		mapped = 1'b1;
		rd_val = PMO_RST_VAL;
		case (off)
			PMO_OFF_MCTL:  rd_val[PMO_BIT_QUPD0] = queued;
			PMO_OFF_SYNC:  rd_val[PMO_BIT_RST0] = rst_pend;
			PMO_OFF_PEN:   rd_val[1:0] = pin_en;
			PMO_OFF_INV:   rd_val[1:0] = inv;
			PMO_OFF_FLT:   rd_val[1:0] = flt_force;
			PMO_OFF_MIEN: begin
				rd_val[PMO_BIT_IFAULT] = mien_fault;
				rd_val[PMO_BIT_IGEN0]  = mien_gen;
			end
			PMO_OFF_MRIS: begin
				rd_val[PMO_BIT_IFAULT] = fault_latch;
				rd_val[PMO_BIT_IGEN0]  = gen_int;
			end
			PMO_OFF_MISC: begin
				rd_val[PMO_BIT_IFAULT] = fault_latch & mien_fault;
				rd_val[PMO_BIT_IGEN0]  = gen_int & mien_gen;
			end
			PMO_OFF_STAT:  rd_val[0] = fault_s;
			PMO_OFF_GCTL:  rd_val[PMO_GCTL_W-1:0] = gctl;
			PMO_OFF_GIEN:  rd_val[PMO_NUM_EV-1:0] = gien;
			PMO_OFF_GRIS:  rd_val[PMO_NUM_EV-1:0] = gris;
			PMO_OFF_GISC:  rd_val[PMO_NUM_EV-1:0] = gris & gien;
			PMO_OFF_LOAD:  rd_val[CNT_W-1:0] = load_reg;
			PMO_OFF_COUNT: rd_val[CNT_W-1:0] = cnt;
			PMO_OFF_CMPA:  rd_val[CNT_W-1:0] = cmpa_reg;
			PMO_OFF_CMPB:  rd_val[CNT_W-1:0] = cmpb_reg;
			PMO_OFF_ACTA:  rd_val[PMO_ACT_W-1:0] = act_a;
			PMO_OFF_ACTB:  rd_val[PMO_ACT_W-1:0] = act_b;
			PMO_OFF_DBCTL: rd_val[PMO_BIT_DBEN] = db_en;
			PMO_OFF_DBRIS: rd_val[CNT_W-1:0] = db_rise;
			PMO_OFF_DBFAL: rd_val[CNT_W-1:0] = db_fall;
			default:       mapped = 1'b0;
		endcase
	end

	// apb answer: one wait-free access, data captured at setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= PMO_RST_VAL;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pready  <= 1'b1;
			prdata  <= (pwrite || !hit) ? PMO_RST_VAL : rd_val;
			pslverr <= !(hit && mapped);
		end else if (acc) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// async pins pass two flops before use
	pmo_sync2 #(
		.W (2)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({debug_stall, fault_in}),
		.q       ({dbg_s, fault_s})
	);

	assign fault_cond = fault_s | dbg_s;

	// plain read/write configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_en     <= '0;
			inv        <= '0;
			flt_force  <= '0;
			mien_fault <= 1'b0;
			mien_gen   <= 1'b0;
			gctl       <= '0;
			gien       <= '0;
			act_a      <= '0;
			act_b      <= '0;
			db_en      <= 1'b0;
			db_rise    <= '0;
			db_fall    <= '0;
		end else if (wr) begin
			case (off)
				PMO_OFF_PEN:   pin_en <= pwdata[1:0];
				PMO_OFF_INV:   inv <= pwdata[1:0];
				PMO_OFF_FLT:   flt_force <= pwdata[1:0];
				PMO_OFF_MIEN: begin
					mien_fault <= pwdata[PMO_BIT_IFAULT];
					mien_gen   <= pwdata[PMO_BIT_IGEN0];
				end
				PMO_OFF_GCTL:  gctl <= pwdata[PMO_GCTL_W-1:0];
				PMO_OFF_GIEN:  gien <= pwdata[PMO_NUM_EV-1:0];
				PMO_OFF_ACTA:  act_a <= pwdata[PMO_ACT_W-1:0];
				PMO_OFF_ACTB:  act_b <= pwdata[PMO_ACT_W-1:0];
				PMO_OFF_DBCTL: db_en <= pwdata[PMO_BIT_DBEN];
				PMO_OFF_DBRIS: db_rise <= pwdata[CNT_W-1:0];
				PMO_OFF_DBFAL: db_fall <= pwdata[CNT_W-1:0];
				default:       db_en <= db_en;
			endcase
		end
	end

	// shadow values written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_reg <= '0;
			cmpa_reg <= '0;
			cmpb_reg <= '0;
		end else if (wr) begin
			if (off == PMO_OFF_LOAD)
				load_reg <= pwdata[CNT_W-1:0];
			if (off == PMO_OFF_CMPA)
				cmpa_reg <= pwdata[CNT_W-1:0];
			if (off == PMO_OFF_CMPB)
				cmpb_reg <= pwdata[CNT_W-1:0];
		end
	end

	// counter runs unless disabled or parked at zero in a stall
	assign at_zero = (cnt == '0);
	assign halt    = dbg_s & !gctl[PMO_BIT_DBGRUN] & at_zero;
	assign tick    = gctl[PMO_BIT_EN] & !halt;

	// active values move at counter zero, gated by update mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_act <= '0;
			cmpa_act <= '0;
			cmpb_act <= '0;
		end else if (tick && at_zero) begin
			if (!gctl[PMO_BIT_LDUPD] || queued)
				load_act <= load_reg;
			if (!gctl[PMO_BIT_CAUPD] || queued)
				cmpa_act <= cmpa_reg;
			if (!gctl[PMO_BIT_CBUPD] || queued)
				cmpb_act <= cmpb_reg;
		end
	end

	// queued update: write one sets, zero ignored; set beats self-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			queued <= 1'b0;
		end else if (wr && off == PMO_OFF_MCTL && pwdata[PMO_BIT_QUPD0]) begin
			queued <= 1'b1;
		end else if (tick && at_zero) begin
			queued <= 1'b0;
		end
	end

	// restart request lives one cycle, so a read of zero means done
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_pend <= 1'b0;
		end else if (wr && off == PMO_OFF_SYNC && pwdata[PMO_BIT_RST0]) begin
			rst_pend <= 1'b1;
		end else begin
			rst_pend <= 1'b0;
		end
	end

	// count-down or up/down time base; pin gating never stops it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt    <= '0;
			dir_up <= 1'b1;
		end else if (rst_pend) begin
			cnt    <= '0;
			dir_up <= 1'b1;
		end else if (tick) begin
			if (!gctl[PMO_BIT_MODE]) begin
				cnt <= at_zero ? load_act : cnt - 1'b1;
			end else if (dir_up) begin
				if (cnt >= load_act) begin
					dir_up <= 1'b0;
					cnt    <= at_zero ? cnt : cnt - 1'b1;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end else if (at_zero) begin
				dir_up <= 1'b1;
				cnt    <= (load_act == '0) ? cnt : cnt + 1'b1;
			end else begin
				cnt <= cnt - 1'b1;
			end
		end
	end

	// events; compare matches yield to zero and load
	always_comb begin
		ev = '0;
		if (tick) begin
			ev[PMO_EV_ZERO] = at_zero;
			ev[PMO_EV_LOAD] = (cnt == load_act);
			if (!at_zero && cnt != load_act) begin
				ev[PMO_EV_AUP] = (cnt == cmpa_act) & gctl[PMO_BIT_MODE] & dir_up;
				ev[PMO_EV_ADN] = (cnt == cmpa_act) & !(gctl[PMO_BIT_MODE] & dir_up);
				ev[PMO_EV_BUP] = (cnt == cmpb_act) & gctl[PMO_BIT_MODE] & dir_up;
				ev[PMO_EV_BDN] = (cnt == cmpb_act) & !(gctl[PMO_BIT_MODE] & dir_up);
			end
		end
	end

	// apply per-event actions in event order
	always_comb begin
		next_gen_a = gen_a;
		next_gen_b = gen_b;
		for (int i = 0; i < PMO_NUM_EV; i++) begin
			if (ev[i]) begin
				case (act_a[2*i +: 2])
					PMO_ACT_TOG:  next_gen_a = !next_gen_a;
					PMO_ACT_LOW:  next_gen_a = 1'b0;
					PMO_ACT_HIGH: next_gen_a = 1'b1;
					default:      next_gen_a = next_gen_a;
				endcase
				case (act_b[2*i +: 2])
					PMO_ACT_TOG:  next_gen_b = !next_gen_b;
					PMO_ACT_LOW:  next_gen_b = 1'b0;
					PMO_ACT_HIGH: next_gen_b = 1'b1;
					default:      next_gen_b = next_gen_b;
				endcase
			end
		end
	end

	// raw generator outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gen_a <= 1'b0;
			gen_b <= 1'b0;
		end else begin
			gen_a <= next_gen_a;
			gen_b <= next_gen_b;
		end
	end

	// dead band: delayed rise on a, delayed rise on inverted a
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			db0      <= 1'b0;
			db1      <= 1'b0;
			rise_cnt <= '0;
			fall_cnt <= '0;
		end else if (!db_en) begin
			db0      <= gen_a;
			db1      <= gen_b;
			rise_cnt <= db_rise;
			fall_cnt <= db_fall;
		end else begin
			if (!gen_a) begin
				db0      <= 1'b0;
				rise_cnt <= db_rise;
			end else if (rise_cnt == '0) begin
				db0 <= 1'b1;
			end else begin
				rise_cnt <= rise_cnt - 1'b1;
			end
			if (gen_a) begin
				db1      <= 1'b0;
				fall_cnt <= db_fall;
			end else if (fall_cnt == '0) begin
				db1 <= 1'b1;
			end else begin
				fall_cnt <= fall_cnt - 1'b1;
			end
		end
	end

	// generator status: sticky events, w1c, a new event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gris <= '0;
		end else if (wr && off == PMO_OFF_GISC) begin
			gris <= (gris & ~pwdata[PMO_NUM_EV-1:0]) | ev;
		end else begin
			gris <= gris | ev;
		end
	end

	assign gen_int = |(gris & gien);

	// fault status latched while the pin is high, w1c
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_latch <= 1'b0;
		end else if (fault_s) begin
			fault_latch <= 1'b1;
		end else if (wr && off == PMO_OFF_MISC && pwdata[PMO_BIT_IFAULT]) begin
			fault_latch <= 1'b0;
		end
	end

	// registered level interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= (fault_latch & mien_fault) | (gen_int & mien_gen);
		end
	end

	// pin paths, order kept inside each stage
	pmo_out_stage u_out0 (
		.pclk       (pclk),
		.presetn    (presetn),
		.gen_sig    (db0),
		.pin_enable (pin_en[0]),
		.force_low  (flt_force[0]),
		.fault_cond (fault_cond),
		.invert     (inv[0]),
		.pin        (output_channel_0)
	);

	pmo_out_stage u_out1 (
		.pclk       (pclk),
		.presetn    (presetn),
		.gen_sig    (db1),
		.pin_enable (pin_en[1]),
		.force_low  (flt_force[1]),
		.fault_cond (fault_cond),
		.invert     (inv[1]),
		.pin        (output_channel_1)
	);
endmodule

// File: core/pmo_out_stage.sv
// one channel of the pin conditioning path
// assumes all inputs are on pclk; pin output is registered
`timescale 1ns/100ps
module pmo_out_stage (
	input  wire logic pclk,       // bus clock
	input  wire logic presetn,    // async reset, low
	input  wire logic gen_sig,    // dead-band output
	input  wire logic pin_enable, // gate to the pin
	input  wire logic force_low,  // force low on fault
	input  wire logic fault_cond, // fault or debug stall
	input  wire logic invert,     // active-low pin
	output logic      pin         // to the power stage
);
	logic gated;
	logic forced;

	// gate, then force, then invert
	assign gated  = pin_enable & gen_sig;
	assign forced = (fault_cond & force_low) ? 1'b0 : gated;

	// inverter sees disabled and forced channels too
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin <= 1'b0;
		end else begin
			pin <= forced ^ invert;
		end
	end
endmodule

// File: core/pmo_sync2.sv
// two-flop synchroniser for asynchronous pin levels
// assumes inputs are levels, held at least two pclk periods
`timescale 1ns/100ps
module pmo_sync2 #(
	parameter int W = 1
) (
	input  wire logic         pclk,    // bus clock
	input  wire logic         presetn, // async reset, low
	input  wire logic [W-1:0] d,       // pin level
	output logic      [W-1:0] q        // synchronised level
);
	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// File: verification/pmo_ctrl_bench.sv
// self-checking bench for the pwm module control and output stage
// assumes pmo_ctrl, its checker and the power stage model are compiled
`timescale 1ns/100ps
module pmo_ctrl_bench import pmo_pkg::*; ;
	logic        pclk, presetn, psel, penable, pwrite, debug_stall, trip;
	logic [31:0] paddr, pwdata, prdata, rdat;
	logic        pready, pslverr, rerr, fault_in, irq;
	logic [1:0]  pins;
	int          err_total, n_compared;
	localparam logic [11:0] REGS [22] = '{PMO_OFF_MCTL, PMO_OFF_SYNC, PMO_OFF_PEN,
		PMO_OFF_INV, PMO_OFF_FLT, PMO_OFF_MIEN, PMO_OFF_MRIS, PMO_OFF_MISC, PMO_OFF_STAT,
		PMO_OFF_GCTL, PMO_OFF_GIEN, PMO_OFF_GRIS, PMO_OFF_GISC, PMO_OFF_LOAD, PMO_OFF_COUNT,
		PMO_OFF_CMPA, PMO_OFF_CMPB, PMO_OFF_ACTA, PMO_OFF_ACTB, PMO_OFF_DBCTL,
		PMO_OFF_DBRIS, PMO_OFF_DBFAL};

	pmo_ctrl pmo_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fault_in(fault_in), .debug_stall(debug_stall),
		.output_channel_0(pins[0]), .output_channel_1(pins[1]), .irq(irq));
	pmo_power_stage pmo_power_stage_i (.pclk(pclk), .pin_a(pins[0]), .pin_b(pins[1]),
		.trip(trip), .fault_in(fault_in));

	// 125 mhz bus clock
	initial pclk = 1'b0;
	always #4 pclk = ~pclk;

	task automatic wrap_up;
		if (err_total == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one apb transfer; an idle edge follows so strobes never flip twice in a step
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		logic to;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		to = (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (to) begin
			err_total++;
			wrap_up();
		end
	endtask

	task automatic wr(input logic [11:0] o, input logic [31:0] d);
		apb(1'b1, PMO_BASE_ADDR | 32'(o), d);
	endtask

	task automatic rd(input logic [11:0] o);
		apb(1'b0, PMO_BASE_ADDR | 32'(o), 32'h0);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// every register starts at zero; refused writes leave no trace
	task automatic t_reset_map;
		foreach (REGS[i]) begin
			rd(REGS[i]);
			check("reset value", rdat, 32'h0);
		end
		apb(1'b1, 32'h4002_9008, 32'h3);
		check("foreign base error", 32'(rerr), 32'h1);
		rd(12'h024);
		check("unmapped error", 32'(rerr), 32'h1);
		rd(PMO_OFF_PEN);
		check("refused write", rdat, 32'h0);
	endtask

	// generator held high after its first zero, then every pin setting
	task automatic t_pins;
		logic [3:0] i;
		wr(PMO_OFF_ACTA, 32'h3);
		wr(PMO_OFF_ACTB, 32'h3);
		wr(PMO_OFF_LOAD, 32'ha);
		wr(PMO_OFF_GCTL, 32'h1);
		tick(30);
		for (int k = 0; k < 16; k++) begin
			i = 4'(k);
			wr(PMO_OFF_PEN, {30'h0, i[1:0]});
			wr(PMO_OFF_INV, {30'h0, i[3:2]});
			tick(2);
			check("pin gating", {30'h0, pins}, {30'h0, i[1:0] ^ i[3:2]});
		end
		wr(PMO_OFF_PEN, 32'h3);
		for (int k = 0; k < 16; k++) begin
			i = 4'(k);
			wr(PMO_OFF_FLT, {30'h0, i[1:0]});
			wr(PMO_OFF_INV, {30'h0, i[3:2]});
			trip        <= !i[3];
			debug_stall <= i[3];
			tick(6);
			check("fault force", {30'h0, pins}, {30'h0, ~i[1:0] ^ i[3:2]});
			trip        <= 1'b0;
			debug_stall <= 1'b0;
			tick(6);
		end
	endtask

	task automatic t_restart;
		logic [31:0] a;
		int n;
		wr(PMO_OFF_PEN, 32'h0);
		wr(PMO_OFF_GCTL, 32'h3);
		wr(PMO_OFF_LOAD, 32'h64);
		n = 0;
		do begin
			rd(PMO_OFF_COUNT);
			n++;
		end while (rdat < 32'h1e && n < 100);
		check("count reached", 32'(rdat >= 32'h1e), 32'h1);
		a = rdat;
		rd(PMO_OFF_COUNT);
		check("count runs unpinned", 32'(a !== rdat), 32'h1);
		wr(PMO_OFF_SYNC, 32'h1);
		rd(PMO_OFF_COUNT);
		check("count restarted", 32'(rdat < 32'h8), 32'h1);
		rd(PMO_OFF_SYNC);
		check("restart cleared", rdat, 32'h0);
		// stall with debug-run clear parks the counter at its next zero
		debug_stall <= 1'b1;
		tick(210);
		rd(PMO_OFF_COUNT);
		check("count parked", rdat, 32'h0);
		rd(PMO_OFF_COUNT);
		check("count still parked", rdat, 32'h0);
		wr(PMO_OFF_GCTL, 32'h7);
		rd(PMO_OFF_COUNT);
		check("count runs in stall", 32'(rdat != 32'h0), 32'h1);
		debug_stall <= 1'b0;
	endtask

	// queued period: held back a full period, applied only after the request
	task automatic t_qupd;
		logic [31:0] mx;
		mx = 0;
		wr(PMO_OFF_GCTL, 32'hb);
		wr(PMO_OFF_LOAD, 32'h14);
		repeat (80) begin
			rd(PMO_OFF_COUNT);
			if (rdat > mx) mx = rdat;
		end
		check("period held back", 32'(mx > 32'h14), 32'h1);
		wr(PMO_OFF_SYNC, 32'h1);
		wr(PMO_OFF_MCTL, 32'h1);
		rd(PMO_OFF_MCTL);
		check("queued set", rdat, 32'h1);
		wr(PMO_OFF_MCTL, 32'h0);
		rd(PMO_OFF_MCTL);
		check("zero write ignored", rdat, 32'h1);
		tick(220);
		rd(PMO_OFF_MCTL);
		check("queued cleared", rdat, 32'h0);
		mx = 0;
		repeat (20) begin
			rd(PMO_OFF_COUNT);
			if (rdat > mx) mx = rdat;
		end
		check("period applied", 32'(mx <= 32'h14), 32'h1);
	endtask

	task automatic t_irq;
		wr(PMO_OFF_MIEN, 32'h0);
		wr(PMO_OFF_MISC, 32'h1_0000);
		rd(PMO_OFF_MRIS);
		check("fault latch clear", rdat & 32'h1_0000, 32'h0);
		trip <= 1'b1;
		tick(6);
		trip <= 1'b0;
		tick(4);
		rd(PMO_OFF_MRIS);
		check("fault latched", rdat & 32'h1_0000, 32'h1_0000);
		check("irq masked", 32'(irq), 32'h0);
		wr(PMO_OFF_MIEN, 32'h1_0000);
		tick(1);
		check("irq raised", 32'(irq), 32'h1);
		rd(PMO_OFF_MISC);
		check("irq status", rdat & 32'h1_0000, 32'h1_0000);
		wr(PMO_OFF_MISC, 32'h1_0000);
		tick(1);
		check("irq cleared", 32'(irq), 32'h0);
		// fault with its mask open raises the line; a few edges more let the checker see it
		trip <= 1'b1;
		tick(6);
		check("irq on fault", 32'(irq), 32'h1);
		tick(2);
		trip <= 1'b0;
	endtask

	// reset, then scenarios in turn
	initial begin
		presetn     = 1'b0;
		psel        = 1'b0;
		penable     = 1'b0;
		pwrite      = 1'b0;
		paddr       = 32'h0;
		pwdata      = 32'h0;
		debug_stall = 1'b0;
		trip        = 1'b0;
		err_total   = 0;
		n_compared  = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset_map();
		t_pins();
		t_restart();
		t_qupd();
		t_irq();
		wrap_up();
	end
endmodule

bind pmo_ctrl pmo_ctrl_checker pmo_ctrl_checker_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .fault_in(fault_in),
	.debug_stall(debug_stall), .output_channel_0(output_channel_0),
	.output_channel_1(output_channel_1), .irq(irq));

// File: verification/pmo_ctrl_checker.sv
// port checker for the pwm module control and output stage
// assumes a bind onto pmo_ctrl; shadows a few registers from accepted apb writes
`timescale 1ns/100ps
module pmo_ctrl_checker
	import pmo_pkg::*;
(
	input wire logic        pclk,             // bus clock
	input wire logic        presetn,          // async reset, low
	input wire logic        psel,             // apb select
	input wire logic        penable,          // apb access
	input wire logic        pwrite,           // apb direction
	input wire logic [31:0] paddr,            // apb address
	input wire logic [31:0] pwdata,           // apb write data
	input wire logic [31:0] prdata,           // apb read data
	input wire logic        pready,           // apb ready
	input wire logic        pslverr,          // apb error
	input wire logic        fault_in,         // fault pin
	input wire logic        debug_stall,      // debugger halt
	input wire logic        output_channel_0, // pin 0
	input wire logic        output_channel_1, // pin 1
	input wire logic        irq               // interrupt
);
	logic [1:0] pen;  // shadow pin enables
	logic [1:0] inv;  // shadow inversion
	logic [1:0] flt;  // shadow force low
	logic [1:0] mien; // shadow irq mask, fault then generator
	logic       wr;   // write accepted this edge
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// shadows follow only writes that were not refused
	assign wr = psel && penable && pready && pwrite && !pslverr;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pen  <= 2'h0;
			inv  <= 2'h0;
			flt  <= 2'h0;
			mien <= 2'h0;
		end else if (wr) begin
			if (paddr[11:0] == PMO_OFF_PEN) pen <= pwdata[1:0];
			if (paddr[11:0] == PMO_OFF_INV) inv <= pwdata[1:0];
			if (paddr[11:0] == PMO_OFF_FLT) flt <= pwdata[1:0];
			if (paddr[11:0] == PMO_OFF_MIEN) mien <= {pwdata[16], pwdata[0]};
		end
	end

	// pin checks allow the two sync flops plus the output flop
	a_ready_next: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_once: assert property (pready |=> !pready)
		else $error("ready held two cycles");
	a_base_err: assert property (pready && paddr[31:12] != 20'h40028 |-> pslverr)
		else $error("foreign base not refused");
	a_map_ok: assert property (pready && paddr == (PMO_BASE_ADDR | 32'h8) |-> !pslverr)
		else $error("mapped register refused");
	a_force_low: assert property ((fault_in && flt[0])[*4] |=> output_channel_0 == $past(inv[0]))
		else $error("forced pin wrong");
	a_stall_fault: assert property ((debug_stall && flt[1])[*4] |=> output_channel_1 == $past(inv[1]))
		else $error("stall did not force pin");
	a_gate_zero: assert property ((!fault_in && !debug_stall && !pen[0])[*4]
		|=> output_channel_0 == $past(inv[0]))
		else $error("disabled pin wrong");
	a_fault_irq: assert property ((fault_in && mien[1])[*4] |=> irq)
		else $error("fault irq missing");
	a_irq_masked: assert property ((mien == 2'h0)[*2] |=> !irq)
		else $error("irq while masked");
	c_refused: cover property (pready && pslverr);
	c_restart: cover property (wr && paddr[11:0] == PMO_OFF_SYNC);
	c_irq: cover property (irq);
endmodule

// File: verification/pmo_power_stage.sv
// power stage switch driver model on the two pwm pins
// assumes the bench commands a fault report through trip
`timescale 1ns/100ps
module pmo_power_stage (
	input  wire logic pclk,    // bus clock
	input  wire logic pin_a,   // switch drive, channel 0
	input  wire logic pin_b,   // switch drive, channel 1
	input  wire logic trip,    // command: report a fault
	output logic      fault_in // fault report to the pwm unit
);
	// report lags the command by a clock, like a latched comparator
	initial fault_in = 1'b0;
	always @(posedge pclk) fault_in <= trip;
endmodule
